// ---- logic/sotp_ctrl.sv ----
// secured otp mode and security lock register command interpreter
// assumes the host keeps cs_n high through power transitions and waits out its power-up delay
// Operation
// - an otp-enter opcode framed alone by cs_n switches accesses to the 4K-bit otp area.
// - an otp-exit opcode framed alone by cs_n leaves otp access mode.
// - in otp mode ordinary reads and page programs target the otp area.
// - in otp mode the status write and lock register write commands are refused.
// - once the otp area is locked only reads act on it and programs are ignored.
// - in otp mode the main array cannot be accessed.
// - the lock register read is answered at any time, even while the device is busy.
// - after the lock register read opcode the 8-bit value shifts out repeatedly until cs_n rises.
// - bit0 of the lock register shows the factory lock state, 1 meaning factory locked.
// - bit1 is the customer lock bit and once set it and the otp area stay fixed until a reset clears the bit.
// - the lock register write runs without a prior write enable.
// - the lock register write is a bare opcode and is rejected unless cs_n rises on a byte edge.
// - at power-up the device is in standby with the write enable latch cleared.
`timescale 1ns/1ps
module sotp_ctrl (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	input wire logic factory_lock_in,
	output logic so,
	output logic so_oe,
	output logic otp_mode,
	output logic main_array_en,
	output logic write_enable_latch,
	output logic [7:0] lock_reg_value,
	output logic read_req,
	output logic prog_req,
	output logic status_write_req
);

	logic rst_meta_r, rst_sync_n;
	logic frame_start, frame_end, sclk_fall, byte_done, aligned;
	logic [7:0] byte_val;
	sotp_pkg::sotp_state_e state_r, state_nxt;
	logic [7:0] opcode_r, opcode_nxt;
	logic [1:0] byte_cnt_r, byte_cnt_nxt;
	logic [2:0] bit_idx_r, bit_idx_nxt;
	logic so_r, so_nxt;
	logic otp_r, otp_nxt;
	logic wel_r, wel_nxt;
	logic lock_r, lock_nxt;
	logic factory_r, factory_nxt;
	logic strap_done_r, strap_done_nxt;
	logic read_r, read_nxt;
	logic prog_r, prog_nxt;
	logic swr_r, swr_nxt;
	logic bare_ok;
	logic otp_locked;
	logic [7:0] secreg;

	// true for commands that must arrive as a lone opcode byte
	function automatic logic is_bare(input logic [7:0] op);
		is_bare = (op == sotp_pkg::OTP_ENTER_CMD) || (op == sotp_pkg::OTP_EXIT_CMD) ||
			(op == sotp_pkg::LOCK_REG_WRITE_CMD) || (op == sotp_pkg::STATUS_WRITE_CMD) ||
			(op == sotp_pkg::WRITE_ENABLE_CMD);
	endfunction

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	// stands in for the internal power-on reset; release is synchronised
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_n <= rst_meta_r;
		end
	end

	sotp_serial_rx u_rx (
		.clk_sys(clk_sys),
		.rst_sync_n(rst_sync_n),
		.cs_n(cs_n),
		.sclk(sclk),
		.si(si),
		.frame_start(frame_start),
		.frame_end(frame_end),
		.sclk_fall(sclk_fall),
		.byte_done(byte_done),
		.byte_val(byte_val),
		.aligned(aligned)
	);

	// ------------------------------------------------------------
	// command decode and mode state
	// ------------------------------------------------------------
	assign otp_locked = lock_r || factory_r;
	assign secreg = {sotp_pkg::LOCK_REG_RSVD, lock_r, factory_r};
	// a bare command runs only when exactly one whole byte preceded cs_n rising
	assign bare_ok = frame_end && (state_r == sotp_pkg::ST_WAIT) &&
		(byte_cnt_r == sotp_pkg::BYTES_ONE) && aligned;

	always_comb begin
		state_nxt = state_r;
		opcode_nxt = opcode_r;
		byte_cnt_nxt = byte_cnt_r;
		bit_idx_nxt = bit_idx_r;
		so_nxt = so_r;
		otp_nxt = otp_r;
		wel_nxt = wel_r;
		lock_nxt = lock_r;
		read_nxt = 1'b0;
		prog_nxt = 1'b0;
		swr_nxt = 1'b0;
		case (state_r)
			sotp_pkg::ST_IDLE: begin
				byte_cnt_nxt = sotp_pkg::BYTES_NONE;
				if (frame_start) begin
					state_nxt = sotp_pkg::ST_OPCODE;
				end
			end
			sotp_pkg::ST_OPCODE: begin
				if (byte_done) begin
					opcode_nxt = byte_val;
					byte_cnt_nxt = sotp_pkg::BYTES_ONE;
					// no busy gating here: the lock register read is always served
					if (byte_val == sotp_pkg::LOCK_REG_READ_CMD) begin
						state_nxt = sotp_pkg::ST_READOUT;
						bit_idx_nxt = sotp_pkg::BIT_CNT_LAST;
					end else if (byte_val == sotp_pkg::DATA_READ_CMD) begin
						state_nxt = sotp_pkg::ST_PASS;
						read_nxt = 1'b1;
					end else if (byte_val == sotp_pkg::PAGE_PROG_CMD) begin
						state_nxt = sotp_pkg::ST_PASS;
						prog_nxt = !(otp_r && otp_locked);
					end else begin
						state_nxt = sotp_pkg::ST_WAIT;
					end
				end
			end
			sotp_pkg::ST_READOUT: begin
				// msb first, wrapping so the value repeats while clocks continue
				if (sclk_fall) begin
					so_nxt = secreg[bit_idx_r];
					bit_idx_nxt = bit_idx_r - 3'h1;
				end
			end
			sotp_pkg::ST_WAIT: begin
				if (byte_done) begin
					byte_cnt_nxt = sotp_pkg::BYTES_MANY;
				end
			end
			sotp_pkg::ST_PASS: begin
				state_nxt = sotp_pkg::ST_PASS;
			end
			default: begin
				state_nxt = sotp_pkg::ST_IDLE;
			end
		endcase
		if (frame_end) begin
			state_nxt = sotp_pkg::ST_IDLE;
			so_nxt = 1'b0;
		end
		if (bare_ok && is_bare(opcode_r)) begin
			case (opcode_r)
				sotp_pkg::OTP_ENTER_CMD: otp_nxt = 1'b1;
				sotp_pkg::OTP_EXIT_CMD: otp_nxt = 1'b0;
				sotp_pkg::WRITE_ENABLE_CMD: wel_nxt = 1'b1;
				sotp_pkg::STATUS_WRITE_CMD: begin
					if (wel_r && !otp_r) begin
						swr_nxt = 1'b1;
						wel_nxt = 1'b0;
					end
				end
				sotp_pkg::LOCK_REG_WRITE_CMD: begin
					// no latch check here, unlike the status write; otp mode still refuses
					if (!otp_r) begin
						lock_nxt = 1'b1;
					end
				end
				default: otp_nxt = otp_r;
			endcase
		end
	end

	// strap is caught on the first clock after release, never by the reset itself
	always_comb begin
		factory_nxt = factory_r;
		strap_done_nxt = 1'b1;
		if (!strap_done_r) begin
			factory_nxt = factory_lock_in;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_r <= sotp_pkg::ST_IDLE;
			opcode_r <= 8'h00;
			byte_cnt_r <= sotp_pkg::BYTES_NONE;
			bit_idx_r <= sotp_pkg::BIT_CNT_LAST;
			so_r <= 1'b0;
			otp_r <= 1'b0;
			wel_r <= 1'b0;
			lock_r <= sotp_pkg::LOCK_RESET;
			factory_r <= 1'b0;
			strap_done_r <= 1'b0;
			read_r <= 1'b0;
			prog_r <= 1'b0;
			swr_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			opcode_r <= opcode_nxt;
			byte_cnt_r <= byte_cnt_nxt;
			bit_idx_r <= bit_idx_nxt;
			so_r <= so_nxt;
			otp_r <= otp_nxt;
			wel_r <= wel_nxt;
			lock_r <= lock_nxt;
			factory_r <= factory_nxt;
			strap_done_r <= strap_done_nxt;
			read_r <= read_nxt;
			prog_r <= prog_nxt;
			swr_r <= swr_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign so = so_r;
	assign so_oe = (state_r == sotp_pkg::ST_READOUT);
	assign otp_mode = otp_r;
	assign main_array_en = !otp_r;
	assign write_enable_latch = wel_r;
	assign lock_reg_value = secreg;
	assign read_req = read_r;
	assign prog_req = prog_r;
	assign status_write_req = swr_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_sync_n);

	sequence bare_exec(logic [7:0] op);
		bare_ok && (opcode_r == op);
	endsequence

	otp_enter_a: assert property (bare_exec(sotp_pkg::OTP_ENTER_CMD) |=> otp_mode && !main_array_en)
		else $error("otp enter did not take effect");
	otp_exit_a: assert property (bare_exec(sotp_pkg::OTP_EXIT_CMD) |=> !otp_mode && main_array_en)
		else $error("otp exit did not take effect");
	otp_persist_a: assert property (!frame_end |=> $stable(otp_mode))
		else $error("otp mode changed outside a frame end");
	status_refuse_a: assert property ((otp_mode and bare_exec(sotp_pkg::STATUS_WRITE_CMD)) |=> !status_write_req)
		else $error("status write accepted in otp mode");
	locked_prog_a: assert property (byte_done && (byte_val == sotp_pkg::PAGE_PROG_CMD) && otp_mode && lock_reg_value[sotp_pkg::CUSTOMER_LOCK_BIT] |=> !prog_req)
		else $error("program issued to locked otp area");
	// a read pulse must come from a data read opcode decoded at the head of a frame
	read_target_a: assert property (read_req |-> $past(byte_done && (byte_val == sotp_pkg::DATA_READ_CMD) && (state_r == sotp_pkg::ST_OPCODE)) && (main_array_en != otp_mode))
		else $error("read request without a decoded data read");
	readout_start_a: assert property (byte_done && (byte_val == sotp_pkg::LOCK_REG_READ_CMD) && !frame_end && state_r == sotp_pkg::ST_OPCODE |=> so_oe)
		else $error("lock register read not answered");
	readout_hold_a: assert property (so_oe && !frame_end |=> so_oe)
		else $error("serial output dropped before deselect");
	readout_stop_a: assert property (frame_end |=> !so_oe ##1 !so_oe)
		else $error("serial output still driven after deselect");
	customer_lock_a: assert property (lock_reg_value[sotp_pkg::CUSTOMER_LOCK_BIT] |=> lock_reg_value[sotp_pkg::CUSTOMER_LOCK_BIT])
		else $error("customer lock bit cleared");
	lock_no_wel_a: assert property ((bare_exec(sotp_pkg::LOCK_REG_WRITE_CMD) and !otp_mode) |=> lock_reg_value[sotp_pkg::CUSTOMER_LOCK_BIT])
		else $error("lock register write not executed");
	misaligned_a: assert property (frame_end && !aligned |=> $stable(lock_reg_value) && $stable(otp_mode))
		else $error("misaligned frame changed state");

endmodule // sotp_ctrl

// ---- logic/sotp_pkg.sv ----
// constants shared by the secured otp command block and its serial front end
// assumes one system clock that samples the serial pins as synchronous inputs
package sotp_pkg;

	// ------------------------------------------------------------
	// serial framing
	// ------------------------------------------------------------
	localparam int BYTE_BITS = 8;
	localparam logic [2:0] BIT_CNT_FIRST = 3'h0;
	localparam logic [2:0] BIT_CNT_LAST = 3'h7;
	localparam logic [1:0] BYTES_NONE = 2'h0;
	localparam logic [1:0] BYTES_ONE = 2'h1;
	localparam logic [1:0] BYTES_MANY = 2'h2;

	// ------------------------------------------------------------
	// opcodes (values arbitrary, to be set for the real command set)
	// ------------------------------------------------------------
	localparam logic [7:0] OTP_ENTER_CMD = 8'h11;
	localparam logic [7:0] OTP_EXIT_CMD = 8'h12;
	localparam logic [7:0] LOCK_REG_READ_CMD = 8'h13;
	localparam logic [7:0] LOCK_REG_WRITE_CMD = 8'h14;
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h15;
	localparam logic [7:0] WRITE_ENABLE_CMD = 8'h16;
	localparam logic [7:0] DATA_READ_CMD = 8'h17;
	localparam logic [7:0] PAGE_PROG_CMD = 8'h18;

	// ------------------------------------------------------------
	// security lock register layout
	// ------------------------------------------------------------
	localparam int LOCK_REG_WIDTH = 8;
	localparam int FACTORY_LOCK_BIT = 0;
	localparam int CUSTOMER_LOCK_BIT = 1;
	localparam logic [5:0] LOCK_REG_RSVD = 6'h00;
	localparam logic LOCK_RESET = 1'b0;
	localparam int OTP_AREA_BITS = 4096;

	// ------------------------------------------------------------
	// frame states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPCODE,
		ST_READOUT,
		ST_PASS,
		ST_WAIT
	} sotp_state_e;

endpackage

// ---- logic/sotp_serial_rx.sv ----
// serial front end: edge detection of the serial clock and byte assembly
// assumes cs_n, sclk and si are synchronous to clk_sys and reset is already synchronised
`timescale 1ns/1ps
module sotp_serial_rx (
	input wire logic clk_sys,
	input wire logic rst_sync_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	output logic frame_start,
	output logic frame_end,
	output logic sclk_fall,
	output logic byte_done,
	output logic [7:0] byte_val,
	output logic aligned
);

	logic sclk_q_r, sclk_q_nxt;
	logic cs_q_r, cs_q_nxt;
	logic [2:0] bit_cnt_r, bit_cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [7:0] byte_r, byte_nxt;
	logic done_r, done_nxt;
	logic sclk_rise;

	// ------------------------------------------------------------
	// edge strobes
	// ------------------------------------------------------------
	assign sclk_rise = sclk && !sclk_q_r && !cs_n;
	assign sclk_fall = !sclk && sclk_q_r && !cs_n;
	assign frame_start = !cs_n && cs_q_r;
	assign frame_end = cs_n && !cs_q_r;
	assign aligned = (bit_cnt_r == sotp_pkg::BIT_CNT_FIRST);
	assign byte_done = done_r;
	assign byte_val = byte_r;

	// bit counter restarts at every select so a partial frame cannot skew the next one
	always_comb begin
		sclk_q_nxt = sclk;
		cs_q_nxt = cs_n;
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt = shift_r;
		byte_nxt = byte_r;
		done_nxt = 1'b0;
		if (frame_start) begin
			bit_cnt_nxt = sotp_pkg::BIT_CNT_FIRST;
		end else if (sclk_rise) begin
			shift_nxt = {shift_r[6:0], si};
			bit_cnt_nxt = bit_cnt_r + 3'h1;
			if (bit_cnt_r == sotp_pkg::BIT_CNT_LAST) begin
				byte_nxt = {shift_r[6:0], si};
				done_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sclk_q_r <= 1'b0;
			cs_q_r <= 1'b1;
			bit_cnt_r <= sotp_pkg::BIT_CNT_FIRST;
			shift_r <= 8'h00;
			byte_r <= 8'h00;
			done_r <= 1'b0;
		end else begin
			sclk_q_r <= sclk_q_nxt;
			cs_q_r <= cs_q_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			byte_r <= byte_nxt;
			done_r <= done_nxt;
		end
	end

endmodule // sotp_serial_rx

// ---- testbench/sotp_host_model.sv ----
// host serial controller model driving the secured otp command block
// assumes clk_sys is the device clock; the bench top calls frame() by hierarchy
`timescale 1ns/1ps
module sotp_host_model (
	input wire logic clk_sys,
	input wire logic so,
	output logic cs_n,
	output logic sclk,
	output logic si
);
	// deselected and quiet from time zero, so power-up never sees a frame
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end

	// wait n edges, then step just past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// nb opcode bits msb first, then nr read clocks; each sclk phase spans three
	// device clocks so the sampler never misses a level; nb not a multiple of 8 breaks framing
	task automatic frame(input logic [7:0] op, input int nb, input int nr, output logic [7:0] rd);
		rd = 8'h00;
		cs_n = 1'b0;
		tick(3);
		for (int i = 0; i < nb + nr; i++) begin
			sclk = 1'b0;
			si = (i < nb) ? op[7 - (i % 8)] : ~si;
			tick(3);
			sclk = 1'b1;
			if (i >= nb) rd = {rd[6:0], so};
			tick(3);
		end
		sclk = 1'b0;
		tick(3);
		cs_n = 1'b1;
		si = ~si;
		tick(4);
	endtask
endmodule // sotp_host_model

// ---- testbench/sotp_ctrl_tb.sv ----
// self-checking bench for the secured otp command block
// assumes the host model sources cs_n, sclk and si while so comes from the block; pulse outputs are counted here
`timescale 1ns/1ps
module sotp_ctrl_tb;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic factory_lock_in = 1'b0;
	logic cs_n, sclk, si, so, so_oe, otp_mode, main_array_en, write_enable_latch;
	logic read_req, prog_req, status_write_req;
	logic [7:0] lock_reg_value, rd;
	int miscompares = 0;
	int check_count = 0;
	int cycles = 0;
	int n_rd = 0;
	int n_pg = 0;
	int n_sw = 0;

	always #12.5 clk_sys = ~clk_sys;

	sotp_ctrl i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .si(si),
		.factory_lock_in(factory_lock_in), .so(so), .so_oe(so_oe), .otp_mode(otp_mode),
		.main_array_en(main_array_en), .write_enable_latch(write_enable_latch),
		.lock_reg_value(lock_reg_value), .read_req(read_req), .prog_req(prog_req),
		.status_write_req(status_write_req));

	sotp_host_model i_host (.clk_sys(clk_sys), .so(so), .cs_n(cs_n), .sclk(sclk), .si(si));

	// ------------------------------------------------------------
	// pulse counters and hang guard
	// ------------------------------------------------------------
	// whole run needs about 2300 cycles; the ceiling leaves ample margin
	always @(posedge clk_sys) begin
		cycles++;
		n_rd += (read_req === 1'b1);
		n_pg += (prog_req === 1'b1);
		n_sw += (status_write_req === 1'b1);
		if (cycles == 30000) begin
			miscompares++;
			conclude();
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// async assert off the edge, hold 12 cycles, then wait until frames are allowed
	task automatic do_reset(input logic fl);
		rst_n = 1'b0;
		factory_lock_in = fl;
		repeat (12) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
	endtask

	// one command frame, judged by how many pulses of each kind it caused
	task automatic req(input logic [7:0] op, input int nb, input logic [7:0] er,
		input logic [7:0] ep, input logic [7:0] es);
		int r0, p0, s0;
		r0 = n_rd;
		p0 = n_pg;
		s0 = n_sw;
		i_host.frame(op, nb, 0, rd);
		chk("read_req pulses", er, 8'(n_rd - r0));
		chk("prog_req pulses", ep, 8'(n_pg - p0));
		chk("status_write_req pulses", es, 8'(n_sw - s0));
	endtask

	// second readout byte proves the value wraps back to bit7
	task automatic t_rdreg(input logic [7:0] exp);
		i_host.frame(sotp_pkg::LOCK_REG_READ_CMD, 8, 16, rd);
		chk("lock read data", exp, rd);
		chk("lock_reg_value", exp, lock_reg_value);
		chk("so_oe after frame", 8'h00, {7'h00, so_oe});
	endtask

	task automatic t_mode(input logic exp);
		chk("otp_mode", {7'h00, exp}, {7'h00, otp_mode});
		chk("main_array_en", {7'h00, ~exp}, {7'h00, main_array_en});
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_power_up();
		t_mode(1'b0);
		chk("write_enable_latch", 8'h00, {7'h00, write_enable_latch});
		t_rdreg(8'h00);
	endtask

	task automatic t_wel();
		req(sotp_pkg::STATUS_WRITE_CMD, 8, 8'h00, 8'h00, 8'h00);
		req(sotp_pkg::WRITE_ENABLE_CMD, 8, 8'h00, 8'h00, 8'h00);
		chk("write_enable_latch", 8'h01, {7'h00, write_enable_latch});
		req(sotp_pkg::STATUS_WRITE_CMD, 8, 8'h00, 8'h00, 8'h01);
		chk("write_enable_latch", 8'h00, {7'h00, write_enable_latch});
		req(8'h00, 8, 8'h00, 8'h00, 8'h00);
		req(sotp_pkg::PAGE_PROG_CMD, 16, 8'h00, 8'h01, 8'h00);
	endtask

	// mode entry refused on a short frame, then refusals and retargeting inside
	task automatic t_otp();
		req(sotp_pkg::OTP_ENTER_CMD, 7, 8'h00, 8'h00, 8'h00);
		t_mode(1'b0);
		req(sotp_pkg::OTP_ENTER_CMD, 8, 8'h00, 8'h00, 8'h00);
		t_mode(1'b1);
		req(sotp_pkg::WRITE_ENABLE_CMD, 8, 8'h00, 8'h00, 8'h00);
		req(sotp_pkg::STATUS_WRITE_CMD, 8, 8'h00, 8'h00, 8'h00);
		req(sotp_pkg::LOCK_REG_WRITE_CMD, 8, 8'h00, 8'h00, 8'h00);
		t_rdreg(8'h00);
		req(sotp_pkg::DATA_READ_CMD, 8, 8'h01, 8'h00, 8'h00);
		req(sotp_pkg::PAGE_PROG_CMD, 16, 8'h00, 8'h01, 8'h00);
		req(sotp_pkg::OTP_EXIT_CMD, 9, 8'h00, 8'h00, 8'h00);
		t_mode(1'b1);
		req(sotp_pkg::OTP_EXIT_CMD, 8, 8'h00, 8'h00, 8'h00);
		t_mode(1'b0);
	endtask

	// customer lock: framing, no latch needed, then programs blocked in otp mode
	task automatic t_lock();
		req(sotp_pkg::STATUS_WRITE_CMD, 8, 8'h00, 8'h00, 8'h01);
		req(sotp_pkg::LOCK_REG_WRITE_CMD, 9, 8'h00, 8'h00, 8'h00);
		chk("lock_reg_value", 8'h00, lock_reg_value);
		req(sotp_pkg::LOCK_REG_WRITE_CMD, 8, 8'h00, 8'h00, 8'h00);
		chk("lock_reg_value", 8'h02, lock_reg_value);
		req(sotp_pkg::OTP_ENTER_CMD, 8, 8'h00, 8'h00, 8'h00);
		req(sotp_pkg::PAGE_PROG_CMD, 16, 8'h00, 8'h00, 8'h00);
		req(sotp_pkg::DATA_READ_CMD, 8, 8'h01, 8'h00, 8'h00);
		req(sotp_pkg::OTP_EXIT_CMD, 8, 8'h00, 8'h00, 8'h00);
		t_rdreg(8'h02);
	endtask

	// reset taken inside otp mode, then the factory strap locks programs
	task automatic t_factory();
		req(sotp_pkg::OTP_ENTER_CMD, 8, 8'h00, 8'h00, 8'h00);
		do_reset(1'b1);
		t_mode(1'b0);
		t_rdreg(8'h01);
		req(sotp_pkg::OTP_ENTER_CMD, 8, 8'h00, 8'h00, 8'h00);
		req(sotp_pkg::PAGE_PROG_CMD, 16, 8'h00, 8'h00, 8'h00);
		req(sotp_pkg::OTP_EXIT_CMD, 8, 8'h00, 8'h00, 8'h00);
	endtask

	initial begin
		do_reset(1'b0);
		t_power_up();
		t_wel();
		t_otp();
		t_lock();
		t_factory();
		conclude();
	end
endmodule // sotp_ctrl_tb
